// ==== design/smsel_top.sv ====
/*
 * Servo control mode selector: picks the active control loop, tracks position
 * commands and reports command readiness; registers over AHB-Lite.
 * Assumes pins are asynchronous to i_clk and a single AHB-Lite master.
 */
// Design decisions made here: the register offsets and the AHB-Lite register port.
// Summary of operation
// - mode field 0..7; 0 position, 1 speed, 2 torque loop.
// - mode 3 toggles position/torque by mode switch 0.
// - mode 4 toggles position/speed by mode switch 0.
// - mode 5 toggles torque/speed by mode switch 0.
// - mode field read/write anytime, resets to 0, applies immediately.
// - hybrid switch changes apply while running, in real time.
// - position target from command count, speed from command rate.
// - fallback bit7 set and fieldbus absent selects internal command sources.
// - commands accepted only after ready output, which follows drive enable.
`timescale 1ns/10ps
`default_nettype none
module smsel_top #(
   parameter int RATE_WIN_CYC = smsel_pkg::RATE_WIN_CYC
) (
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic             o_hreadyout,
   output logic             o_hresp,
   output logic [31:0]      o_hrdata,
   input  wire logic        i_mode_switch_in0,
   input  wire logic        i_mode_switch_in1,
   input  wire logic        i_drive_enable_in,
   input  wire logic        i_fieldbus_link,
   input  wire logic        i_pos_step,
   input  wire logic        i_pos_dir,
   output logic [1:0]       o_active_loop,
   output logic             o_command_accept_ready,
   output logic             o_internal_cmd_src
);
   if (RATE_WIN_CYC < 2) begin : g_chk
      $error("rate window too short");
   end

   smsel_pos_if pos ();

   // pin synchronisers: sync1 feeds only sync2
   logic [smsel_pkg::SYNC_W-1:0] sync1_q, sync2_q, pins;
   logic                         step_prev_q;
   logic                         sw0_s, sw1_s, en_s, link_s, step_s, dir_s;

   assign pins = {i_pos_dir, i_pos_step, i_fieldbus_link, i_drive_enable_in,
                  i_mode_switch_in1, i_mode_switch_in0};

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         sync1_q     <= '0;
         sync2_q     <= '0;
         step_prev_q <= 1'b0;
      end else begin
         sync1_q     <= pins;
         sync2_q     <= sync1_q;
         step_prev_q <= sync2_q[4];
      end
   end

   assign {dir_s, step_s, link_s, en_s, sw1_s, sw0_s} = sync2_q;

   // configuration and control state
   logic [2:0]                  mode_q, mode_d;
   logic [7:0]                  fallback_q, fallback_d;
   smsel_pkg::smsel_loop_t      loop_q, loop_d;
   logic                        ready_q, ready_d;
   logic                        internal_q, internal_d;

   // bus state
   logic                        wr_pend_q, wr_pend_d;
   logic [7:0]                  wr_ofs_q, wr_ofs_d;
   logic [31:0]                 rdata_q, rdata_d;
   logic                        addr_ok;
   logic [7:0]                  ofs;

   always_comb begin
      addr_ok   = i_hsel && i_hready && i_htrans[1];
      ofs       = i_haddr[7:0];
      // writes above the mapped page must not alias onto the registers
      wr_pend_d = addr_ok && i_hwrite && i_haddr[31:8] == '0;
      wr_ofs_d  = addr_ok ? ofs : wr_ofs_q;
      rdata_d   = rdata_q;
      if (addr_ok && !i_hwrite) begin
         rdata_d = '0;
         if (i_haddr[31:8] == '0) begin
            case (ofs)
               smsel_pkg::OFS_MODE:      rdata_d[2:0] = mode_q;
               smsel_pkg::OFS_FALLBACK:  rdata_d[7:0] = fallback_q;
               smsel_pkg::OFS_STATUS: begin
                  rdata_d[smsel_pkg::ST_LOOP_LSB +: 2] = loop_q;
                  rdata_d[smsel_pkg::ST_READY]         = ready_q;
                  rdata_d[smsel_pkg::ST_INTERNAL]      = internal_q;
                  rdata_d[smsel_pkg::ST_SW0]           = sw0_s;
                  rdata_d[smsel_pkg::ST_SW1]           = sw1_s;
                  rdata_d[smsel_pkg::ST_ENABLE]        = en_s;
                  rdata_d[smsel_pkg::ST_LINK]          = link_s;
               end
               smsel_pkg::OFS_POS_COUNT: rdata_d = pos.count;
               smsel_pkg::OFS_POS_RATE:  rdata_d[smsel_pkg::RATE_W-1:0] = pos.rate;
               default:                  rdata_d = '0;
            endcase
         end
      end
   end

   always_comb begin
      mode_d     = mode_q;
      fallback_d = fallback_q;
      if (wr_pend_q) begin
         case (wr_ofs_q)
            smsel_pkg::OFS_MODE: begin
               if (i_hwdata[31:3] == '0) begin
                  mode_d = i_hwdata[2:0];
               end
            end
            smsel_pkg::OFS_FALLBACK: fallback_d = i_hwdata[7:0];
            default: fallback_d = fallback_q;
         endcase
      end
      loop_d     = smsel_pkg::smsel_decode(mode_q, sw0_s, sw1_s);
      ready_d    = en_s;
      internal_d = fallback_q[smsel_pkg::FALLBACK_BIT] && !link_s;
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         mode_q     <= smsel_pkg::MODE_RST;
         fallback_q <= smsel_pkg::FALLBACK_RST;
         loop_q     <= smsel_pkg::LOOP_POS;
         ready_q    <= 1'b0;
         internal_q <= 1'b0;
         wr_pend_q  <= 1'b0;
         wr_ofs_q   <= '0;
         rdata_q    <= '0;
      end else begin
         mode_q     <= mode_d;
         fallback_q <= fallback_d;
         loop_q     <= loop_d;
         ready_q    <= ready_d;
         internal_q <= internal_d;
         wr_pend_q  <= wr_pend_d;
         wr_ofs_q   <= wr_ofs_d;
         rdata_q    <= rdata_d;
      end
   end

   // counting only in position loop once ready keeps early pulses out of the target
   assign pos.step   = step_s && !step_prev_q;
   assign pos.dir    = dir_s;
   assign pos.enable = ready_q && loop_q == smsel_pkg::LOOP_POS;

   smsel_pos_acc #(
      .WIN_CYC (RATE_WIN_CYC)
   ) u_acc (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .pos      (pos)
   );

   assign o_hreadyout            = 1'b1;
   assign o_hresp                = 1'b0;
   assign o_hrdata               = rdata_q;
   assign o_active_loop          = loop_q;
   assign o_command_accept_ready = ready_q;
   assign o_internal_cmd_src     = internal_q;

   chk_fixed_mode_loop: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (mode_q == smsel_pkg::MODE_TRQ) |=> loop_q == smsel_pkg::LOOP_TRQ)
      else $error("torque mode did not select torque loop");
   chk_pt_switch_map: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (mode_q == smsel_pkg::MODE_PT) |=>
         loop_q == ($past(sw0_s) ? smsel_pkg::LOOP_TRQ : smsel_pkg::LOOP_POS))
      else $error("mode 3 loop wrong");
   chk_ps_switch_map: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (mode_q == smsel_pkg::MODE_PS && !sw0_s) |=> loop_q == smsel_pkg::LOOP_POS)
      else $error("mode 4 loop wrong");
   chk_ts_switch_map: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (mode_q == smsel_pkg::MODE_TS && !sw0_s) |=> loop_q == smsel_pkg::LOOP_TRQ)
      else $error("mode 5 loop wrong");
   chk_pts_sw1_wins: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (mode_q == smsel_pkg::MODE_PTS && sw1_s) |=> loop_q == smsel_pkg::LOOP_POS)
      else $error("mode 6 switch 1 ignored");
   chk_mode_write_apply: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (wr_pend_q && wr_ofs_q == smsel_pkg::OFS_MODE && i_hwdata[31:3] == '0)
         |=> mode_q == $past(i_hwdata[2:0]) ##1 loop_q == smsel_pkg::smsel_decode(
            $past(mode_q), $past(sw0_s), $past(sw1_s)))
      else $error("mode write not applied");
   chk_runtime_switch: assert property (@(posedge i_clk) disable iff (!i_resetn)
      ($rose(i_mode_switch_in0) && mode_q == smsel_pkg::MODE_PS)
         ##1 (i_mode_switch_in0 && mode_q == smsel_pkg::MODE_PS)[*2]
         |=> loop_q == smsel_pkg::LOOP_SPD)
      else $error("switch change not applied within three cycles");
   chk_fallback_internal: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (fallback_q[7] && !link_s) |=> o_internal_cmd_src)
      else $error("fallback did not select internal sources");
   chk_ready_gates_cmds: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (!en_s |=> !o_command_accept_ready) and (!o_command_accept_ready |-> !pos.enable))
      else $error("commands accepted without ready");
   chk_mode_bad_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (wr_pend_q && wr_ofs_q == smsel_pkg::OFS_MODE && i_hwdata[31:3] != '0) |=> $stable(mode_q))
      else $error("out of range mode accepted");

endmodule // smsel_top
`default_nettype wire

// ==== design/smsel_pkg.sv ====
/*
 * Shared constants, types and the loop decoder for the servo control mode selector.
 * Assumes a single 25 MHz clock domain and 32-bit AHB-Lite register access.
 */
package smsel_pkg;

   localparam int CLK_PERIOD_NS = 40;
   localparam int RATE_WIN_US   = 1000;
   localparam int RATE_WIN_CYC  = (RATE_WIN_US * 1000) / CLK_PERIOD_NS;

   // register byte offsets
   localparam logic [7:0] OFS_MODE      = 8'h00;
   localparam logic [7:0] OFS_FALLBACK  = 8'h04;
   localparam logic [7:0] OFS_STATUS    = 8'h08;
   localparam logic [7:0] OFS_POS_COUNT = 8'h0C;
   localparam logic [7:0] OFS_POS_RATE  = 8'h10;

   // control_mode_select encodings
   localparam int         MODE_W      = 3;
   localparam logic [2:0] MODE_POS    = 3'h0;
   localparam logic [2:0] MODE_SPD    = 3'h1;
   localparam logic [2:0] MODE_TRQ    = 3'h2;
   localparam logic [2:0] MODE_PT     = 3'h3;
   localparam logic [2:0] MODE_PS     = 3'h4;
   localparam logic [2:0] MODE_TS     = 3'h5;
   localparam logic [2:0] MODE_PTS    = 3'h6;
   localparam logic [2:0] MODE_RST    = 3'h0;

   localparam logic [7:0] FALLBACK_RST = 8'h00;
   localparam int         FALLBACK_BIT = 7;

   // status field positions
   localparam int ST_LOOP_LSB = 0;
   localparam int ST_READY    = 2;
   localparam int ST_INTERNAL = 3;
   localparam int ST_SW0      = 4;
   localparam int ST_SW1      = 5;
   localparam int ST_ENABLE   = 6;
   localparam int ST_LINK     = 7;

   localparam int POS_CNT_W = 32;
   localparam int RATE_W    = 16;
   localparam int SYNC_W    = 6;

   typedef enum logic [1:0] {LOOP_POS, LOOP_SPD, LOOP_TRQ} smsel_loop_t;

   // mode 7 has no defined loop here and falls back to position control
   function automatic smsel_loop_t smsel_decode(input logic [2:0] mode,
                                                input logic       sw0,
                                                input logic       sw1);
      smsel_loop_t r;
      r = LOOP_POS;
      case (mode)
         MODE_POS: r = LOOP_POS;
         MODE_SPD: r = LOOP_SPD;
         MODE_TRQ: r = LOOP_TRQ;
         MODE_PT:  r = sw0 ? LOOP_TRQ : LOOP_POS;
         MODE_PS:  r = sw0 ? LOOP_SPD : LOOP_POS;
         MODE_TS:  r = sw0 ? LOOP_SPD : LOOP_TRQ;
         MODE_PTS: r = sw1 ? LOOP_POS : (sw0 ? LOOP_TRQ : LOOP_SPD);
         default:  r = LOOP_POS;
      endcase
      return r;
   endfunction

endpackage

// ==== design/smsel_pos_if.sv ====
/*
 * Carrier between the selector and its position command accumulator.
 * Assumes both ends share the selector clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface smsel_pos_if;
   logic                            step;
   logic                            dir;
   logic                            enable;
   logic [smsel_pkg::POS_CNT_W-1:0] count;
   logic [smsel_pkg::RATE_W-1:0]    rate;
   modport src (output step, output dir, output enable, input count, input rate);
   modport acc (input step, input dir, input enable, output count, output rate);
endinterface
`default_nettype wire

// ==== design/smsel_pos_acc.sv ====
/*
 * Position command accumulator: signed command count and commands per window.
 * Assumes step is a one-cycle pulse already synchronised to i_clk.
 */
`timescale 1ns/10ps
`default_nettype none
module smsel_pos_acc #(
   parameter int WIN_CYC = smsel_pkg::RATE_WIN_CYC
) (
   input  wire logic    i_clk,
   input  wire logic    i_resetn,
   smsel_pos_if.acc     pos
);
   localparam int WW = $clog2(WIN_CYC);
   localparam logic [WW-1:0] WIN_LAST = WW'(WIN_CYC - 1);

   if (WIN_CYC < 2) begin : g_chk
      $error("window must be at least two cycles");
   end

   logic [smsel_pkg::POS_CNT_W-1:0] cnt_q, cnt_d;
   logic [smsel_pkg::RATE_W-1:0]    tally_q, tally_d, rate_q, rate_d, tally_inc;
   logic [WW-1:0]                   win_q, win_d;
   logic                            hit;

   always_comb begin
      hit       = pos.enable && pos.step;
      cnt_d     = cnt_q;
      if (hit) begin
         cnt_d = pos.dir ? cnt_q - 1'b1 : cnt_q + 1'b1;
      end
      // saturate so a burst cannot wrap into a tiny rate
      tally_inc = (hit && tally_q != '1) ? tally_q + 1'b1 : tally_q;
      tally_d   = tally_inc;
      rate_d    = rate_q;
      win_d     = win_q + 1'b1;
      if (win_q == WIN_LAST) begin
         win_d   = '0;
         rate_d  = tally_inc;
         tally_d = '0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         cnt_q   <= '0;
         tally_q <= '0;
         rate_q  <= '0;
         win_q   <= '0;
      end else begin
         cnt_q   <= cnt_d;
         tally_q <= tally_d;
         rate_q  <= rate_d;
         win_q   <= win_d;
      end
   end

   assign pos.count = cnt_q;
   assign pos.rate  = rate_q;

   chk_count_up_step: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (pos.enable && pos.step && !pos.dir) |=> cnt_q == $past(cnt_q) + 1'b1)
      else $error("forward command not counted");
   chk_count_idle_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
      !(pos.enable && pos.step) |=> $stable(cnt_q))
      else $error("count moved without an accepted command");

endmodule // smsel_pos_acc
`default_nettype wire

// ==== tb/smsel_host_model.sv ====
/*
 * Host side model: drives mode switches, enable, link and position command pulses.
 * Assumes the bench sets its controls just after a rising edge of i_clk.
 */
`timescale 1ns/10ps
`default_nettype none
module smsel_host_model (
   input  wire logic       i_clk,
   input  wire logic [1:0] i_sw,
   input  wire logic       i_en,
   input  wire logic       i_link,
   input  wire logic       i_dir,
   input  wire logic       i_go,
   input  wire logic [7:0] i_n,
   output logic            o_sw0,
   output logic            o_sw1,
   output logic            o_en,
   output logic            o_link,
   output logic            o_dir,
   output logic            o_step,
   output logic            o_busy
);
   logic [7:0] left_q;
   logic [2:0] ph_q;
   // pulses are whole: 4 clocks high, 4 low, well above the 2-clock minimum
   always @(posedge i_clk) begin
      if (i_go) begin
         left_q <= i_n;
         ph_q   <= 3'h0;
      end else if (left_q != 8'h00) begin
         ph_q <= ph_q + 3'h1;
         if (ph_q == 3'h7) left_q <= left_q - 8'h01;
      end
   end
   initial left_q = 8'h00;
   initial ph_q = 3'h0;
   assign o_busy = (left_q != 8'h00);
   assign o_step = o_busy && !ph_q[2];
   assign o_sw0  = i_sw[0];
   assign o_sw1  = i_sw[1];
   assign o_en   = i_en;
   assign o_link = i_link;
   assign o_dir  = i_dir;
endmodule // smsel_host_model
`default_nettype wire

// ==== tb/servo_control_mode_selector_tb_top.sv ====
/*
 * Self-checking bench for the mode selector: AHB-Lite register tasks plus host model.
 * Assumes zero-wait AHB-Lite slave and a small rate window for short runs.
 */
`timescale 1ns/10ps
`default_nettype none
module servo_control_mode_selector_tb_top;
   logic i_clk = 1'b0, i_resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
   logic [1:0] htrans = 2'h0, sw = 2'h0, loop;
   logic en = 1'b0, link = 1'b1, dir = 1'b0, go = 1'b0, hro, ready, intl;
   logic [7:0] npl = 8'h00;
   logic sw0, sw1, pen, plink, pdir, step, busy;
   logic [31:0] hrdata;
   logic hresp;
   int n_fail = 0, samples_checked = 0, cyc = 0, m, s;
   always #20 i_clk = ~i_clk;
   smsel_top #(.RATE_WIN_CYC(64)) DUT (.i_clk(i_clk), .i_resetn(i_resetn), .i_hsel(hsel),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
      .i_hwdata(hwdata), .i_hready(hro), .o_hreadyout(hro), .o_hresp(hresp),
      .o_hrdata(hrdata), .i_mode_switch_in0(sw0), .i_mode_switch_in1(sw1),
      .i_drive_enable_in(pen), .i_fieldbus_link(plink), .i_pos_step(step),
      .i_pos_dir(pdir), .o_active_loop(loop), .o_command_accept_ready(ready),
      .o_internal_cmd_src(intl));
   smsel_host_model host (.i_clk(i_clk), .i_sw(sw), .i_en(en), .i_link(link), .i_dir(dir),
      .i_go(go), .i_n(npl), .o_sw0(sw0), .o_sw1(sw1), .o_en(pen), .o_link(plink),
      .o_dir(pdir), .o_step(step), .o_busy(busy));
   task automatic print_verdict;
      if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   // address phase held until hready, then data phase held until hready again
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge i_clk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h000000, a};
      hwrite <= w;
      do @(posedge i_clk); while (hro !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge i_clk); while (hro !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task automatic pulses(input logic [7:0] n);
      @(posedge i_clk);
      npl <= n;
      go  <= 1'b1;
      @(posedge i_clk);
      go  <= 1'b0;
      // let the model load its count so busy is already high on return
      @(posedge i_clk);
   endtask
   function automatic logic [31:0] exp_loop(input int md, input logic s0, input logic s1);
      case (md)
         1: return 32'h1;
         2: return 32'h2;
         3: return s0 ? 32'h2 : 32'h0;
         4: return s0 ? 32'h1 : 32'h0;
         5: return s0 ? 32'h1 : 32'h2;
         6: return s1 ? 32'h0 : (s0 ? 32'h2 : 32'h1);
         default: return 32'h0;
      endcase
   endfunction
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         print_verdict();
      end
   end
   initial begin
      wt(4);
      i_resetn <= 1'b1;
      wt(1);
      ahb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0);
      chk({30'h0, loop}, 32'h0);
      chk({31'h0, ready}, 32'h0);
      for (m = 0; m < 8; m++) begin
         ahb(1'b1, 8'h00, m);
         // switches change with the mode held, so each change must apply live
         for (s = 0; s < 4; s++) begin
            sw <= s[1:0];
            wt(5);
            chk({30'h0, loop}, exp_loop(m, s[0], s[1]));
         end
      end
      ahb(1'b1, 8'h00, 32'h8);
      ahb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h7);
      ahb(1'b1, 8'h00, 32'h1);
      ahb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h1);
      wt(4);
      chk({30'h0, loop}, 32'h1);
      ahb(1'b0, 8'h20, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      ahb(1'b1, 8'h04, 32'h80);
      ahb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h80);
      link <= 1'b0;
      wt(5);
      chk({31'h0, intl}, 32'h1);
      link <= 1'b1;
      wt(5);
      chk({31'h0, intl}, 32'h0);
      ahb(1'b1, 8'h00, 32'h0);
      pulses(8'h03);
      wait (busy === 1'b0);
      wt(4);
      ahb(1'b0, 8'h0C, 32'h0);
      chk(rd, 32'h0);
      en <= 1'b1;
      wt(5);
      chk({31'h0, ready}, 32'h1);
      ahb(1'b0, 8'h08, 32'h0);
      chk(rd, 32'h000000F4);
      pulses(8'h28);
      wt(200);
      ahb(1'b0, 8'h10, 32'h0);
      chk(rd, 32'h8);
      wait (busy === 1'b0);
      wt(4);
      ahb(1'b0, 8'h0C, 32'h0);
      chk(rd, 32'h28);
      ahb(1'b1, 8'h0C, 32'h0);
      dir <= 1'b1;
      pulses(8'h05);
      wait (busy === 1'b0);
      wt(4);
      ahb(1'b0, 8'h0C, 32'h0);
      chk(rd, 32'h23);
      en <= 1'b0;
      wt(5);
      chk({31'h0, ready}, 32'h0);
      print_verdict();
   end
endmodule // servo_control_mode_selector_tb_top
`default_nettype wire
